// ===== include/sensor_path_pkg.sv
// Constants for the linearization, trim, clamp and PWM output path
package sensor_path_pkg;
  // ----------------------------------------------------------------
  // Configuration word map
  // ----------------------------------------------------------------
  localparam logic [7:0] CLAMP_ADDR = 8'h08;
  localparam logic [7:0] LIN_BASE_ADDR = 8'h0A;
  localparam logic [7:0] LIN_CTRL_ADDR = 8'h12;
  localparam logic [7:0] TRIM_ADDR = 8'h13;
  localparam logic [7:0] OUT_CFG_ADDR = 8'h14;
  localparam int WORD_W = 26;
  localparam int LIN_WORDS = 9;
  localparam logic [25:0] WORD_RESET = 26'h0000000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENT_W = 13;
  localparam int LINT_E_BIT = 13;
  localparam int BIN_E_BIT = 14;
  localparam int OUT_INV_BIT = 15;
  localparam int IN_INV_BIT = 16;
  localparam int HYST_LSB = 17;
  localparam int HYST_W = 8;
  localparam int SCALAR_BIT = 25;
  localparam int SENS_LSB = 0;
  localparam int QVO_LSB = 12;
  localparam int TRIM_W = 12;
  localparam int CLAMPH_LSB = 0;
  localparam int CLAMPL_LSB = 12;
  localparam int FMT_LSB = 0;
  localparam int FMT_W = 3;
  localparam int RATE_LSB = 3;
  localparam int RATE_W = 4;
  // ----------------------------------------------------------------
  // Encodings and scaling
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_PWM = 3'h0;
  localparam logic signed [18:0] LOC_MID = 19'sh01000;
  localparam int LOC_SHIFT = 3;
  localparam int COEF_SHIFT = 2;
  localparam int SEG_FRAC_W = 12;
  localparam int SENS_SHIFT = 11;
  localparam logic [3:0] CLAMPH_FILL = 4'hF;
  localparam logic [3:0] CLAMPL_FILL = 4'h0;
  localparam int PWM_FULL_BITS = 16;
endpackage

// ===== hw/bin_lut_trim_clamp_pwm_path.sv
// Linearization, post trim, clamp and PWM output stage of the sensor path
`timescale 1ns/1ns
// Summary of operation
// - Binning selected: no interpolation, emit discrete level of matched bin.
// - Edge is 8*(loc-4096); below first edge -32768 if loc0 nonzero; top is level 7.
// - Hysteresis lowers bin edges only while the signal is falling.
// - Word 0x12 bit 13 enables the linearization table.
// - Word 0x12 bit 14 picks binning mode, else interpolated mode.
// - Word 0x12 bit 15 inverts the linearization output.
// - Word 0x12 bit 16 inverts the linearization input.
// - Hysteresis amount is word 0x12 bits 24:17.
// - Word 0x12 bit 25 doubles the linearization levels and interpolated corrections; bin edges are not doubled.
// - Trim output is value times one plus gain, plus offset, 16-bit signed.
// - Gain trim is word 0x13 bits 11:0, steps of 2^-11.
// - Offset trim is word 0x13 bits 23:12, steps of 16 LSB.
// - Trimmed signed value becomes unsigned by adding 32768.
// - Above upper limit gives upper, below lower gives lower, else pass.
// - Upper limit is word 0x8 bits 11:0 in steps of 16.
// - Lower limit is word 0x8 bits 23:12 in steps of 16.
// - Clamp passes a 16-bit unsigned value to output formatting.
// - PWM is fixed frequency with duty proportional to clamped value.
// - Output format field word 0x14 bits 2:0 equal zero selects PWM.
// - Word 0x14 bits 6:3 set the PWM carrier frequency.
// - During serial programming the pin carries programming traffic, not output.
// - Bin locations are 13-bit unsigned, offset by 4096 from signed input.
// - Interpolated mode uses 17 evenly spaced points with linear interpolation.
module bin_lut_trim_clamp_pwm_path #(
  parameter int PWM_CNT_BITS = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [25:0] cfg_wdata,
  output logic [25:0] cfg_rdata,
  input wire logic y2_valid,
  input wire logic signed [15:0] y2_in,
  output logic y6_valid,
  output logic [15:0] y6_out,
  input wire logic prog_active,
  input wire logic prog_drive_low,
  output logic prog_rx,
  input wire logic out_pin_i,
  output logic out_pin_o,
  output logic out_pin_oe
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (PWM_CNT_BITS < 4 || PWM_CNT_BITS > sensor_path_pkg::PWM_FULL_BITS)
    begin : g_bad
      $error("PWM_CNT_BITS must be 4 to 16");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Configuration words
  // ----------------------------------------------------------------
  logic [25:0] lin_word [0:sensor_path_pkg::LIN_WORDS-1];
  logic [25:0] clamp_limits_word;
  logic [25:0] post_trim_word;
  logic [25:0] output_config_word;
  logic [7:0] lin_idx;

  assign lin_idx = cfg_addr - sensor_path_pkg::LIN_BASE_ADDR;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < sensor_path_pkg::LIN_WORDS; i++)
        lin_word[i] <= sensor_path_pkg::WORD_RESET;
      clamp_limits_word <= sensor_path_pkg::WORD_RESET;
      post_trim_word <= sensor_path_pkg::WORD_RESET;
      output_config_word <= sensor_path_pkg::WORD_RESET;
    end
    else if (cfg_wr_en)
    begin
      if (cfg_addr >= sensor_path_pkg::LIN_BASE_ADDR && cfg_addr <= sensor_path_pkg::LIN_CTRL_ADDR)
        lin_word[lin_idx[3:0]] <= cfg_wdata;
      else if (cfg_addr == sensor_path_pkg::CLAMP_ADDR)
        clamp_limits_word <= cfg_wdata;
      else if (cfg_addr == sensor_path_pkg::TRIM_ADDR)
        post_trim_word <= cfg_wdata;
      else if (cfg_addr == sensor_path_pkg::OUT_CFG_ADDR)
        output_config_word <= cfg_wdata;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cfg_rdata <= sensor_path_pkg::WORD_RESET;
    else if (cfg_addr >= sensor_path_pkg::LIN_BASE_ADDR
             && cfg_addr <= sensor_path_pkg::LIN_CTRL_ADDR)
      cfg_rdata <= lin_word[lin_idx[3:0]];
    else if (cfg_addr == sensor_path_pkg::CLAMP_ADDR)
      cfg_rdata <= clamp_limits_word;
    else if (cfg_addr == sensor_path_pkg::TRIM_ADDR)
      cfg_rdata <= post_trim_word;
    else if (cfg_addr == sensor_path_pkg::OUT_CFG_ADDR)
      cfg_rdata <= output_config_word;
    else
      cfg_rdata <= sensor_path_pkg::WORD_RESET;
  end

  logic [25:0] ctrl;
  logic lint_en, bin_en, out_inv, in_inv, scalar;
  logic [7:0] hyst;

  assign ctrl = lin_word[sensor_path_pkg::LIN_WORDS-1];
  assign lint_en = ctrl[sensor_path_pkg::LINT_E_BIT];
  assign bin_en = ctrl[sensor_path_pkg::BIN_E_BIT];
  assign out_inv = ctrl[sensor_path_pkg::OUT_INV_BIT];
  assign in_inv = ctrl[sensor_path_pkg::IN_INV_BIT];
  assign hyst = ctrl[sensor_path_pkg::HYST_LSB +: sensor_path_pkg::HYST_W];
  assign scalar = ctrl[sensor_path_pkg::SCALAR_BIT];

  // Table entry n: word n/2, low or high 13-bit half
  function automatic logic [12:0] entry(input logic [4:0] n);
    logic [25:0] w;
    w = lin_word[n[4:1]];
    entry = n[0] ? w[25:13] : w[12:0];
  endfunction

  // Saturate a wide signed result to 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [18:0] v);
    if (v > 19'sh07FFF)
      sat16 = 16'sh7FFF;
    else if (v < -19'sh08000)
      sat16 = -16'sh8000;
    else
      sat16 = v[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Direction tracking for hysteresis
  // ----------------------------------------------------------------
  logic signed [15:0] lin_in;
  logic signed [15:0] prev_in;
  logic falling;
  logic dir_fall;

  assign lin_in = in_inv ? ~y2_in : y2_in;
  assign dir_fall = lin_in < prev_in || (lin_in == prev_in && falling);

  // Equal samples keep the last direction so a flat signal does not chatter
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prev_in <= 16'sh0000;
      falling <= 1'b0;
    end
    else if (y2_valid)
    begin
      prev_in <= lin_in;
      falling <= dir_fall;
    end
  end

  // ----------------------------------------------------------------
  // Binning mode
  // ----------------------------------------------------------------
  logic signed [18:0] hyst_amt;
  logic signed [18:0] in19;
  logic signed [15:0] bin_out;

  assign hyst_amt = dir_fall ? $signed({10'h000, hyst, 1'b0}) : 19'sh00000;
  assign in19 = {{3{lin_in[15]}}, lin_in};

  always_comb
  begin
    logic signed [18:0] thr;
    logic signed [18:0] lvl;
    logic [2:0] idx;
    logic hit;
    thr = 19'sh00000;
    lvl = 19'sh00000;
    idx = 3'h0;
    hit = 1'b0;
    for (int x = 0; x < 8; x++)
    begin
      thr = ($signed({6'h00, entry(5'(x))}) - sensor_path_pkg::LOC_MID)
            <<< sensor_path_pkg::LOC_SHIFT;
      thr = thr - hyst_amt;
      if (in19 > thr)
      begin
        idx = 3'(x);
        hit = 1'b1;
      end
    end
    lvl = ($signed({6'h00, entry({2'b01, idx})}) - sensor_path_pkg::LOC_MID)
          <<< sensor_path_pkg::LOC_SHIFT;
    if (scalar)
      lvl = lvl <<< 1;
    if (!hit && entry(5'h00) != 13'h0000)
      bin_out = -16'sh8000;
    else
      bin_out = sat16(lvl);
  end

  // ----------------------------------------------------------------
  // Interpolated mode
  // ----------------------------------------------------------------
  logic signed [15:0] interp_out;

  always_comb
  begin
    logic [15:0] ux;
    logic [3:0] seg;
    logic signed [13:0] k_lo;
    logic signed [13:0] diff;
    logic signed [27:0] prod;
    logic signed [18:0] delta;
    ux = {~lin_in[15], lin_in[14:0]};
    seg = ux[15:12];
    k_lo = $signed(entry({1'b0, seg}));
    diff = $signed(entry(5'(seg) + 5'h01)) - k_lo;
    prod = 28'(diff) * $signed({16'h0000, ux[11:0]});
    delta = 19'(k_lo) + 19'(prod >>> sensor_path_pkg::SEG_FRAC_W);
    delta = delta <<< sensor_path_pkg::COEF_SHIFT;
    if (scalar)
      delta = delta <<< 1;
    interp_out = sat16(in19 + delta);
  end

  // ----------------------------------------------------------------
  // Linearization stage register
  // ----------------------------------------------------------------
  logic signed [15:0] y3;
  logic y3_valid;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      y3 <= 16'sh0000;
      y3_valid <= 1'b0;
    end
    else
    begin
      y3_valid <= y2_valid;
      if (y2_valid)
      begin
        if (!lint_en)
          y3 <= y2_in;
        else if (bin_en)
          y3 <= out_inv ? ~bin_out : bin_out;
        else
          y3 <= out_inv ? ~interp_out : interp_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Post trim and clamp
  // ----------------------------------------------------------------
  logic signed [11:0] sens;
  logic signed [11:0] qvo;
  logic signed [27:0] gain_prod;
  logic signed [18:0] y4_wide;
  logic signed [15:0] y4;
  logic [15:0] y5;
  logic [15:0] clamp_hi;
  logic [15:0] clamp_lo;
  logic [15:0] next_y6;

  assign sens = post_trim_word[sensor_path_pkg::SENS_LSB +: sensor_path_pkg::TRIM_W];
  assign qvo = post_trim_word[sensor_path_pkg::QVO_LSB +: sensor_path_pkg::TRIM_W];
  assign gain_prod = 28'(y3) * 28'(sens);
  assign y4_wide = 19'(y3) + 19'(gain_prod >>> sensor_path_pkg::SENS_SHIFT)
                   + 19'($signed({qvo, 4'h0}));
  assign y4 = sat16(y4_wide);
  assign y5 = {~y4[15], y4[14:0]};
  assign clamp_hi = {clamp_limits_word[sensor_path_pkg::CLAMPH_LSB +: 12],
                     sensor_path_pkg::CLAMPH_FILL};
  assign clamp_lo = {clamp_limits_word[sensor_path_pkg::CLAMPL_LSB +: 12],
                     sensor_path_pkg::CLAMPL_FILL};

  // Upper limit is tested first, so a crossed pair still gives a fixed answer
  always_comb
  begin
    if (y5 > clamp_hi)
      next_y6 = clamp_hi;
    else if (y5 < clamp_lo)
      next_y6 = clamp_lo;
    else
      next_y6 = y5;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      y6_out <= 16'h0000;
      y6_valid <= 1'b0;
    end
    else
    begin
      y6_valid <= y3_valid;
      if (y3_valid)
        y6_out <= next_y6;
    end
  end

  // ----------------------------------------------------------------
  // PWM output
  // ----------------------------------------------------------------
  logic [3:0] rate;
  logic [3:0] prescale;
  logic [PWM_CNT_BITS-1:0] pwm_cnt;
  logic [PWM_CNT_BITS-1:0] duty;
  logic pwm_mode;
  logic tick;

  assign rate = output_config_word[sensor_path_pkg::RATE_LSB +: sensor_path_pkg::RATE_W];
  assign pwm_mode = output_config_word[sensor_path_pkg::FMT_LSB +: sensor_path_pkg::FMT_W]
                    == sensor_path_pkg::FMT_PWM;
  assign tick = prescale >= rate;

  // Period is 2^PWM_CNT_BITS ticks, one tick per rate+1 clocks
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      prescale <= 4'h0;
    else if (tick)
      prescale <= 4'h0;
    else
      prescale <= prescale + 4'h1;
  end

  // Duty is sampled only at the wrap so a period never shows two values
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pwm_cnt <= '0;
      duty <= '0;
    end
    else if (tick)
    begin
      pwm_cnt <= pwm_cnt + PWM_CNT_BITS'(1);
      if (pwm_cnt == '1)
        duty <= y6_out[15 -: PWM_CNT_BITS];
    end
  end

  // Open drain: the pin is only ever pulled low, high is the released state
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      out_pin_oe <= 1'b0;
    else if (prog_active)
      out_pin_oe <= prog_drive_low;
    else if (pwm_mode)
      out_pin_oe <= pwm_cnt >= duty;
    else
      out_pin_oe <= 1'b0;
  end

  assign out_pin_o = 1'b0;
  assign prog_rx = prog_active & out_pin_i;
endmodule

// ===== dv/bin_lut_trim_clamp_pwm_path_assertions.sv
// Port-level checker for the sensor output path
`timescale 1ns/1ns
module bin_lut_trim_clamp_pwm_path_assertions (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [25:0] cfg_wdata,
  input wire logic [25:0] cfg_rdata,
  input wire logic y2_valid,
  input wire logic y6_valid,
  input wire logic [15:0] y6_out,
  input wire logic prog_active,
  input wire logic prog_drive_low,
  input wire logic prog_rx,
  input wire logic out_pin_i,
  input wire logic out_pin_oe
);
  // ----------
  // Shadows of limit and format words
  // ----------
  logic [23:0] lim;
  logic [2:0] fmt;
  wire logic [15:0] hi = {lim[11:0], 4'hF};
  wire logic [15:0] lo = {lim[23:12], 4'h0};
  wire logic mapped = cfg_addr == 8'h08 || (cfg_addr > 8'h09 && cfg_addr < 8'h15);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      lim <= 24'h000000;
    else if (cfg_wr_en && cfg_addr == 8'h08)
      lim <= cfg_wdata[23:0];
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      fmt <= 3'h0;
    else if (cfg_wr_en && cfg_addr == 8'h14)
      fmt <= cfg_wdata[2:0];
  end
  // ----------
  // Assertions
  // ----------
  valid_delay_a: assert property (y2_valid |-> ##2 y6_valid)
    else $error("result late");
  valid_cause_a: assert property (y6_valid |-> $past(y2_valid, 2))
    else $error("result without sample");
  out_hold_a: assert property (!y6_valid && !$past(srst) |-> $stable(y6_out))
    else $error("result moved");
  clamp_top_a: assert property (y6_valid && lo <= hi |-> y6_out <= hi)
    else $error("above upper limit");
  clamp_floor_a: assert property (y6_valid && lo <= hi |-> y6_out >= lo)
    else $error("below lower limit");
  fmt_release_a: assert property ((fmt != 3'h0 && !prog_active) [*2] |-> !out_pin_oe)
    else $error("pin driven outside pwm");
  prog_drive_a: assert property (prog_active |=> out_pin_oe == $past(prog_drive_low))
    else $error("pin not owned by programming");
  prog_rx_a: assert property (prog_active |-> prog_rx == out_pin_i)
    else $error("receive path wrong");
  readback_a: assert property (cfg_wr_en && mapped ##1 $stable(cfg_addr) |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("readback wrong");
  unmapped_zero_a: assert property (!mapped |=> cfg_rdata == 26'h0000000)
    else $error("unmapped read not zero");
  cover property (y6_valid && y6_out == hi);
  cover property (prog_active && out_pin_oe);
  cover property (fmt == 3'h0 && $rose(out_pin_oe));
endmodule

// ===== dv/pwm_reader.sv
// Far-side reader of the output pin
`timescale 1ns/1ns
module pwm_reader (
  input wire logic clk_sys,
  input wire logic pin,
  input wire logic clr,
  input wire logic talk,
  output logic pull_low,
  output int high_cnt
);
  // ----------
  // Duty measurement
  // ----------
  // Pulls low only when told, so the pin stays a wired-AND with pull-up
  assign pull_low = talk;
  always_ff @(posedge clk_sys)
  begin
    high_cnt <= clr ? int'(pin) : high_cnt + int'(pin);
  end
endmodule

// ===== dv/bin_lut_trim_clamp_pwm_path_tb.sv
// Self-checking bench for the sensor output path
`timescale 1ns/1ns
module bin_lut_trim_clamp_pwm_path_tb;
  // ----------
  // Signals and instances
  // ----------
  logic clk_sys = 1'b0, srst = 1'b1, cfg_wr_en = 1'b0, y2_valid = 1'b0, falling = 1'b0;
  logic prog_active = 1'b0, prog_drive_low = 1'b0, clr = 1'b0, talk = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [25:0] cfg_wdata = 26'h0000000, lc = 26'h0000000, tw, cl, q, cfg_rdata;
  logic signed [15:0] y2_in = 16'sh0000, prev = 16'sh0000;
  logic [15:0] y6_out, last_e;
  logic y6_valid, prog_rx, out_pin_o, out_pin_oe, pull_low;
  logic [12:0] tbl [16];
  int error_cnt = 0, num_checks = 0, high_cnt;
  wire logic pin = !(out_pin_oe || pull_low);
  bin_lut_trim_clamp_pwm_path #(.PWM_CNT_BITS(6)) i_bin_lut_trim_clamp_pwm_path (
    .clk_sys(clk_sys), .srst(srst), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .y2_valid(y2_valid), .y2_in(y2_in),
    .y6_valid(y6_valid), .y6_out(y6_out), .prog_active(prog_active),
    .prog_drive_low(prog_drive_low), .prog_rx(prog_rx), .out_pin_i(pin),
    .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe));
  pwm_reader i_pwm_reader (.clk_sys(clk_sys), .pin(pin), .clr(clr), .talk(talk),
    .pull_low(pull_low), .high_cnt(high_cnt));
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------
  // Tasks and reference model
  // ----------
  task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [25:0] d);
    @(negedge clk_sys);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    if (a == 8'h08) cl = d;
    if (a == 8'h12) lc = d;
    if (a == 8'h13) tw = d;
    if (a > 8'h09 && a < 8'h12) {tbl[2 * (a - 8'h0A) + 1], tbl[2 * (a - 8'h0A)]} = d;
    @(negedge clk_sys);
    cfg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    cfg_addr = a;
    @(negedge clk_sys);
    q = cfg_rdata;
  endtask
  // Direction is tracked on every sample, as the device does
  function automatic logic [15:0] model(input logic signed [15:0] y);
    logic signed [15:0] yi;
    int v, k, hy, s, kl, kh;
    yi = lc[16] ? ~y : y;
    if (yi != prev) falling = yi < prev;
    prev = yi;
    v = y;
    if (lc[13])
    begin
      if (lc[14])
      begin
        hy = falling ? 2 * int'(lc[24:17]) : 0;
        k = -1;
        for (int x = 0; x < 8; x++)
          if (8 * (int'(tbl[x]) - 4096) - hy < int'(yi)) k = x;
        if (k < 0 && tbl[0] != 13'h0000) v = -32768;
        else v = 8 * (int'(tbl[k < 0 ? 8 : 8 + k]) - 4096) * (lc[25] ? 2 : 1);
      end
      else
      begin
        s = (int'(yi) + 32768) / 4096;
        kl = int'($signed(tbl[s]));
        kh = s == 15 ? int'($signed(lc[12:0])) : int'($signed(tbl[s + 1]));
        v = (kl + (((kh - kl) * ((int'(yi) + 32768) % 4096)) >>> 12)) * (lc[25] ? 8 : 4);
        v = int'(yi) + v;
      end
      v = v > 32767 ? 32767 : v < -32768 ? -32768 : v;
      if (lc[15]) v = -v - 1;
    end
    v = v + ((v * int'($signed(tw[11:0]))) >>> 11) + 16 * int'($signed(tw[23:12]));
    v = (v > 32767 ? 32767 : v < -32768 ? -32768 : v) + 32768;
    if (v > int'({cl[11:0], 4'hF})) v = {cl[11:0], 4'hF};
    else if (v < int'({cl[23:12], 4'h0})) v = {cl[23:12], 4'h0};
    return 16'(v);
  endfunction
  task automatic send(input logic [15:0] y, input bit c);
    @(negedge clk_sys);
    y2_valid = 1'b1;
    y2_in = y;
    last_e = model(y);
    @(negedge clk_sys);
    y2_valid = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    if (c) chk(y6_out, last_e);
  endtask
  task automatic setclamp;
    logic [11:0] h;
    h = 12'($urandom);
    wr(8'h08, {2'h0, 12'($urandom_range(h, 0)), h});
  endtask
  task automatic pwm(input logic [15:0] y, input logic [3:0] r, input logic [2:0] f);
    int per;
    per = (int'(r) + 1) * 64;
    wr(8'h14, {19'h00000, r, f});
    send(y, 1'b1);
    repeat (2 * per) @(negedge clk_sys);
    clr = 1'b1;
    @(negedge clk_sys);
    clr = 1'b0;
    repeat (per - 1) @(negedge clk_sys);
    chk(high_cnt, f != 3'h0 ? per : int'(last_e[15:10]) * (int'(r) + 1));
  endtask
  // ----------
  // Tests
  // ----------
  initial
  begin
    logic [25:0] d;
    logic [15:0] t;
    logic [7:0] ads [5] = '{8'h08, 8'h12, 8'h13, 8'h14, 8'h09};
    void'($urandom(32'h0D4C));
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    foreach (ads[i])
    begin
      rd(ads[i]);
      chk(q, 26'h0000000);
      d = 26'($urandom);
      if (ads[i] == 8'h08) d[23:12] = 12'h000;
      wr(ads[i], d);
      rd(ads[i]);
      chk(q, ads[i] == 8'h09 ? 26'h0000000 : d);
    end
    $display("register test done");
    wr(8'h12, 26'h0000000);
    for (int c = 0; c < 3; c++)
    begin
      setclamp;
      wr(8'h13, {2'h0, 12'($urandom), 12'h000});
      send(16'h8000, 1'b1);
      send(16'h7FFF, 1'b1);
      repeat (12) send(16'($urandom), 1'b1);
    end
    $display("bypass test done");
    for (int j = 0; j < 4; j++)
    begin
      wr(8'(8'h0A + j), {13'(4096 + (2 * j - 3) * 512), 13'(4096 + (2 * j - 4) * 512)});
      wr(8'(8'h0E + j), 26'($urandom));
    end
    for (int c = 0; c < 6; c++)
    begin
      setclamp;
      wr(8'h13, {2'h0, 12'($urandom), c[0] ? 12'h000 : (c == 2 ? 12'hC00 : 12'h400)});
      wr(8'h12, {1'($urandom), 8'($urandom), 1'($urandom), c[0], 2'h3, 13'h0000});
      send(16'h0000, 1'b0);
      send(16'h0001, 1'b0);
      repeat (40)
      begin
        t = 16'(8 * (int'(tbl[$urandom % 8]) - 4096) + int'($urandom % 3) - 1
          - int'($urandom % 3) * 2 * int'(lc[24:17]));
        if ($urandom % 4 == 0) t = 16'($urandom);
        send(lc[16] ? ~t : t, 1'b1);
      end
    end
    $display("binning test done");
    wr(8'h08, 26'h0000FFF);
    for (int c = 0; c < 2; c++)
    begin
      wr(8'h13, 26'h0000000);
      wr(8'h12, {1'(c), 8'h00, 1'($urandom), 1'($urandom), 2'h1, 13'($urandom)});
      repeat (20) send(16'($urandom), 1'b1);
    end
    $display("interpolation test done");
    wr(8'h12, 26'h0000000);
    wr(8'h13, 26'h0000000);
    for (int r = 0; r < 16; r += 5)
    begin
      pwm(16'h8000, 4'(r), 3'h0);
      pwm(16'h7FFF, 4'(r), 3'h0);
      pwm(16'($urandom), 4'(r), 3'h0);
    end
    pwm(16'h7FFF, 4'h2, 3'h1);
    $display("pwm test done");
    @(negedge clk_sys);
    prog_active = 1'b1;
    prog_drive_low = 1'b1;
    @(negedge clk_sys);
    chk(out_pin_oe, 26'h0000001);
    prog_drive_low = 1'b0;
    talk = 1'b1;
    @(negedge clk_sys);
    chk({out_pin_o, out_pin_oe, prog_rx}, 26'h0000000);
    talk = 1'b0;
    @(negedge clk_sys);
    chk(prog_rx, 26'h0000001);
    prog_active = 1'b0;
    $display("programming test done");
    report_and_stop;
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule
bind bin_lut_trim_clamp_pwm_path bin_lut_trim_clamp_pwm_path_assertions i_chk (
  .clk_sys(clk_sys), .srst(srst), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .y2_valid(y2_valid), .y6_valid(y6_valid),
  .y6_out(y6_out), .prog_active(prog_active), .prog_drive_low(prog_drive_low),
  .prog_rx(prog_rx), .out_pin_i(out_pin_i), .out_pin_oe(out_pin_oe));
